// File: src/qpu_pkg.sv
// Purpose: Shared constants and carriers for the quad-port FIFO unpacker.
// Assumes: 64-bit slots, 32-bit user words with four active-low enables.
// Notes: Byte enables travel active low everywhere.
package qpu_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int unsigned SLOT_W = 64;
    localparam int unsigned HALF_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned SLOT_BE_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned USER_W = 36;

    // ------------------------------------------------------------
    // Enable and data values
    // ------------------------------------------------------------
    localparam logic [3:0] BE_ALL_ON = 4'h0;
    localparam logic [3:0] BE_ALL_OFF = 4'hF;
    localparam logic [31:0] DUMMY_DATA = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // One 64-bit slot as stored in the FIFO.
    typedef struct packed {
        logic [7:0] be_n;
        logic [63:0] data;
    } qpu_slot_s;

    // One word arriving from the PCI engine.
    typedef struct packed {
        logic wide;
        logic last;
        logic [7:0] be_n;
        logic [63:0] data;
    } qpu_in_s;

    // Read-side word state.
    typedef enum logic [1:0] {
        QPU_LOW = 2'b01,
        QPU_HIGH = 2'b10
    } qpu_half_e;

    // Packer state on the fill side.
    typedef enum logic [1:0] {
        QPU_EMPTY = 2'b01,
        QPU_HELD = 2'b10
    } qpu_pack_e;

    localparam int unsigned SLOT_TOT_W = SLOT_W + SLOT_BE_W;

endpackage

// File: src/qpu_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, synchronous active-low reset, enable freezes state.
// Notes: DEPTH must be a power of two.
`timescale 1ns/10ps
module qpu_fifo #(
    parameter int unsigned WIDTH = 72,
    parameter int unsigned DEPTH = 16
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    // Pointer and count state.
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } qpu_fifo_s;

    qpu_fifo_s st_q;
    qpu_fifo_s st_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic do_wr;
    logic do_rd;

    // Full and empty follow the count.
    assign in_ready = (st_q.cnt != DEPTH[AW:0]);
    assign out_valid = (st_q.cnt != '0);
    assign out_data = mem_q[st_q.rd];
    assign do_wr = in_valid & in_ready & clk_en;
    assign do_rd = out_valid & out_ready & clk_en;

    // Next pointer values.
    always_comb begin
        st_d = st_q;
        if (do_wr) begin
            st_d.wr = st_q.wr + 1'b1;
        end
        if (do_rd) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        if (do_wr && !do_rd) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    // Register pointers and write storage.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
        if (do_wr) begin
            mem_q[st_q.wr] <= in_data;
        end
    end

    fifo_bound_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        st_q.cnt <= DEPTH[AW:0])
        else $error("FIFO count above depth.");

endmodule

// File: src/qpu_unpacker.sv
// Purpose: Packs PCI-received data into 64-bit slots and unpacks it to
//          32-bit user words with active-low byte enables.
// Assumes: The PCI engine keeps its own protocol and alignment.
// Notes: Quad-port path only; a low port_quad holds the path idle.
//
// How it works
// - User data path always 32 bits wide.
// - 64-bit transfers stored into slots unchanged.
// - Low half read first, high half second.
// - Four active-low enables ride on bits 35:32.
// - 32-bit words paired, earlier word low half.
// - Odd count pads dummy word, enables F.
// - Same unpacking for target write, master read.
// - Unpacking active only in quad-port arrangement.
`timescale 1ns/10ps
module qpu_unpacker (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Configuration
    input wire logic port_quad,
    // Fill side from the PCI engine
    input wire logic pci_valid,
    input wire qpu_pkg::qpu_in_s pci_word,
    output logic pci_ready,
    // User read side
    output logic [35:0] user_word,
    output logic user_valid,
    input wire logic user_rd
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Slot count wide enough to reach the full depth.
    typedef logic [$clog2(qpu_pkg::FIFO_DEPTH):0] qpu_cnt_t;

    typedef struct packed {
        qpu_pkg::qpu_pack_e pk;
        logic [31:0] held_data;
        logic [3:0] held_be_n;
        qpu_pkg::qpu_half_e hf;
        logic [35:0] out_word;
        logic out_valid;
        logic in_ready;
        logic quad_m;
        logic quad_s;
        qpu_cnt_t slots;
    } qpu_st_s;

    qpu_st_s st_q;
    qpu_st_s st_d;

    // Fill- and drain-side FIFO signals.
    logic f_in_valid;
    logic f_in_ready;
    qpu_pkg::qpu_slot_s f_in;
    logic f_out_valid;
    logic f_out_ready;
    qpu_pkg::qpu_slot_s f_out;
    logic take;
    logic user_take;
    logic quad;
    logic f_wr;
    logic f_pop;

    // Builds one user word from data and its active-low enables.
    function automatic logic [35:0] mk_word(input logic [31:0] d,
                                            input logic [3:0] be);
        mk_word = {be, d};
    endfunction

    // ------------------------------------------------------------
    // Fill side
    // ------------------------------------------------------------
    // An incoming word is accepted only when the FIFO can take a slot.
    // The mode pin is read only after its two-stage synchroniser.
    assign quad = st_q.quad_s;
    assign take = pci_valid & st_q.in_ready & quad & clk_en;
    assign user_take = st_q.out_valid & user_rd & clk_en;
    assign f_wr = f_in_valid & f_in_ready;
    assign f_pop = f_out_ready & f_out_valid;

    // Slot assembly for wide and narrow transfers.
    always_comb begin
        f_in_valid = 1'b0;
        f_in.data = pci_word.data;
        f_in.be_n = pci_word.be_n;
        if (take) begin
            if (pci_word.wide) begin
                f_in_valid = 1'b1;
            end else if (st_q.pk == qpu_pkg::QPU_HELD) begin
                // Earlier word low, later word high.
                f_in_valid = 1'b1;
                f_in.data = {pci_word.data[31:0], st_q.held_data};
                f_in.be_n = {pci_word.be_n[3:0], st_q.held_be_n};
            end else if (pci_word.last) begin
                // Odd count: pad the high half with a dummy word.
                f_in_valid = 1'b1;
                f_in.data = {qpu_pkg::DUMMY_DATA, pci_word.data[31:0]};
                f_in.be_n = {qpu_pkg::BE_ALL_OFF, pci_word.be_n[3:0]};
            end
        end
    end

    qpu_fifo #(
        .WIDTH(qpu_pkg::SLOT_TOT_W),
        .DEPTH(qpu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    // The drain side pops a slot on the edge that loads its high half into the output word.
    assign f_out_ready = clk_en & quad & f_out_valid &
        (st_q.hf == qpu_pkg::QPU_HIGH) &
        (!st_q.out_valid || user_take);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Packer, half selector and registered output word.
    always_comb begin
        st_d = st_q;
        // Two-stage synchroniser for the mode pin.
        st_d.quad_m = port_quad;
        st_d.quad_s = st_q.quad_m;
        // Track slots held so ready never lags a filling FIFO.
        if (f_wr && !f_pop) begin
            st_d.slots = st_q.slots + 1'b1;
        end else if (f_pop && !f_wr) begin
            st_d.slots = st_q.slots - 1'b1;
        end
        // Ready is registered from the room left after this edge.
        st_d.in_ready = st_d.quad_s &
            (st_d.slots != qpu_cnt_t'(qpu_pkg::FIFO_DEPTH));
        if (take && !pci_word.wide) begin
            if (st_q.pk == qpu_pkg::QPU_EMPTY && !pci_word.last) begin
                st_d.pk = qpu_pkg::QPU_HELD;
                st_d.held_data = pci_word.data[31:0];
                st_d.held_be_n = pci_word.be_n[3:0];
            end else begin
                st_d.pk = qpu_pkg::QPU_EMPTY;
            end
        end
        if (user_take) begin
            st_d.out_valid = 1'b0;
        end
        if (quad && f_out_valid && (!st_q.out_valid || user_take)) begin
            st_d.out_valid = 1'b1;
            if (st_q.hf == qpu_pkg::QPU_LOW) begin
                st_d.out_word = mk_word(f_out.data[31:0],
                                        f_out.be_n[3:0]);
                st_d.hf = qpu_pkg::QPU_HIGH;
            end else begin
                st_d.out_word = mk_word(f_out.data[63:32],
                                        f_out.be_n[7:4]);
                st_d.hf = qpu_pkg::QPU_LOW;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    // All state is held in one register.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q.pk <= qpu_pkg::QPU_EMPTY;
            st_q.held_data <= qpu_pkg::ZERO_WORD;
            st_q.held_be_n <= qpu_pkg::BE_ALL_OFF;
            st_q.hf <= qpu_pkg::QPU_LOW;
            st_q.out_word <= {qpu_pkg::BE_ALL_OFF, qpu_pkg::ZERO_WORD};
            st_q.out_valid <= 1'b0;
            st_q.in_ready <= 1'b0;
            st_q.quad_m <= 1'b0;
            st_q.quad_s <= 1'b0;
            st_q.slots <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // The user bus is always a 32-bit word plus enables, from flops.
    assign user_word = st_q.out_word;
    assign user_valid = st_q.out_valid;
    assign pci_ready = st_q.in_ready;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Low half of a slot is loaded into the output word.
    sequence low_shown_s;
        f_out_ready == 1'b0 && st_d.out_valid && st_q.hf == qpu_pkg::QPU_LOW
            && clk_en && quad && f_out_valid
            && (!st_q.out_valid || user_take);
    endsequence

    // First narrow word of a pair is held back.
    sequence pair_first_s;
        take && !pci_word.wide && !pci_word.last &&
            st_q.pk == qpu_pkg::QPU_EMPTY;
    endsequence

    half_order_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        low_shown_s |=> st_q.hf == qpu_pkg::QPU_HIGH)
        else $error("High half not next after low half.");

    low_half_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        low_shown_s |=> user_word == {$past(f_out.be_n[3:0]),
                                      $past(f_out.data[31:0])})
        else $error("Low half word mismatch.");

    high_half_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        low_shown_s ##1 (user_take && quad) |=>
        user_word == {$past(f_out.be_n[7:4]), $past(f_out.data[63:32])})
        else $error("High half word mismatch.");

    wide_pass_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (take && pci_word.wide) |-> f_in_valid && f_in.data == pci_word.data)
        else $error("Wide word altered.");

    fill_room_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        f_in_valid |-> f_in_ready)
        else $error("Slot offered to a full FIFO.");

    pair_pack_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        pair_first_s ##1 (take && !pci_word.wide) |-> f_in_valid &&
        f_in.data[31:0] == $past(pci_word.data[31:0]))
        else $error("Pair packing order wrong.");

    pair_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        pair_first_s ##1 (take && !pci_word.wide) |->
        f_in.data[63:32] == pci_word.data[31:0])
        else $error("Later word not in high half.");

    dummy_pad_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (take && !pci_word.wide && pci_word.last &&
         st_q.pk == qpu_pkg::QPU_EMPTY) |->
        f_in.be_n[7:4] == qpu_pkg::BE_ALL_OFF)
        else $error("Dummy word enables not all off.");

    quad_only_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !quad |-> !take && !f_out_ready)
        else $error("Path active outside quad-port mode.");

    out_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (user_valid && !user_rd && clk_en) |=>
        user_valid && $stable(user_word))
        else $error("User word dropped before read.");

    freeze_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !clk_en |=> $stable(st_q))
        else $error("State moved while enable low.");

endmodule

// File: verification/qpu_user_model.sv
// Purpose: User logic that reads 32-bit words from the unpacker.
// Assumes: A word is taken at a rising edge with valid, read, enable high.
// Notes: The stall input holds off reads so the FIFO backs up.
`timescale 1ns/10ps
module qpu_user_model (
    // Clock and enable
    input wire logic core_clk,
    input wire logic clk_en,
    // Read side of the unpacker
    input wire logic [35:0] user_word,
    input wire logic user_valid,
    output logic user_rd,
    // Control and report towards the bench
    input wire logic stall,
    output logic got,
    output logic [35:0] got_word,
    output logic keep
);
    logic take_s;
    logic stall_s;
    logic [35:0] word_s;

    // Sample before the edge, since the design updates on it.
    always @(negedge core_clk) begin
        take_s = user_valid & user_rd & clk_en;
        word_s = user_word;
        stall_s = stall;
    end

    // Report the taken word and move the read strobe just after the edge.
    always @(posedge core_clk) begin
        #1;
        got = take_s;
        got_word = word_s;
        keep = take_s && (word_s[35:32] != 4'hF);
        user_rd = ~stall_s;
    end

    // Quiet start before the first edge.
    initial begin
        user_rd = 1'b0;
        got = 1'b0;
        got_word = 36'h0;
        keep = 1'b0;
    end
endmodule

// File: verification/quad_port_fifo_unpacker_tb.sv
// Purpose: Self-checking bench for the quad-port FIFO unpacker.
// Assumes: Inputs move 1 ns after the rising edge, sampled at negedge.
// Notes: A queue model predicts every 32-bit word the user reads.
`timescale 1ns/10ps
module quad_port_fifo_unpacker_tb;
    logic core_clk, rst_b, clk_en, port_quad, pci_valid, pci_ready;
    logic user_valid, user_rd, stall, got, keep, held;
    qpu_pkg::qpu_in_s pci_word;
    logic [35:0] user_word, got_word, e;
    logic [35:0] exp_q[$];
    logic [31:0] seed, bseed;
    int error_cnt, comparisons, mode;

    // ------------------------------------------------------------
    // Design, user model and clock
    // ------------------------------------------------------------
    qpu_unpacker u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .clk_en(clk_en), .port_quad(port_quad), .pci_valid(pci_valid),
        .pci_word(pci_word), .pci_ready(pci_ready), .user_word(user_word),
        .user_valid(user_valid), .user_rd(user_rd));
    qpu_user_model u_user (.core_clk(core_clk), .clk_en(clk_en),
        .user_word(user_word), .user_valid(user_valid), .user_rd(user_rd),
        .stall(stall), .got(got), .got_word(got_word), .keep(keep));

    // The clock toggles every 25 ns for a 50 ns period.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [35:0] exp,
                       input logic [35:0] seen);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Offer one engine word, hold it until taken, then update the model.
    task automatic send(input logic w, input logic l, input logic [7:0] be,
                        input logic [63:0] d);
        int n;
        bit ok;
        pci_word = {w, l, be, d};
        pci_valid = 1'b1;
        ok = 1'b0;
        n = 0;
        while (!ok && n < 200) begin
            @(negedge core_clk);
            ok = (pci_ready & clk_en & port_quad) === 1'b1;
            @(posedge core_clk);
            #1;
            n++;
        end
        if (!ok) chk("pci_ready", 36'h1, 36'h0);
        exp_q.push_back({be[3:0], d[31:0]});
        if (w) exp_q.push_back({be[7:4], d[63:32]});
        if (!w && l && !held) exp_q.push_back({4'hF, 32'h0});
        if (!w) held = !held && !l;
    endtask

    // A burst starts on a fresh slot, so wide bursts are quadword aligned.
    task automatic burst(input logic w, input int len, input logic rbe);
        logic [63:0] d;
        for (int i = 0; i < len; i++) begin
            seed = lfsr(seed);
            d[31:0] = seed;
            seed = lfsr(seed);
            d[63:32] = seed;
            send(w, i == len - 1, rbe ? seed[7:0] : 8'h00, d);
        end
        pci_valid = 1'b0;
    endtask

    task automatic wait_empty();
        for (int i = 0; i < 500 && exp_q.size() != 0; i++) begin
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        #1;
        chk("words_left", 36'h0, exp_q.size());
    endtask

    // Every word the user takes is matched against the model.
    always @(negedge core_clk) begin
        if (got === 1'b1) begin
            if (exp_q.size() == 0) chk("extra_word", 36'h0, got_word);
            else begin
                e = exp_q.pop_front();
                chk("keep", {35'h0, e[35:32] != 4'hF}, {35'h0, keep});
                chk("user_be_n", e[35:32], got_word[35:32]);
                if (e[35:32] != 4'hF) begin
                    chk("user_data", e[31:0], got_word[31:0]);
                end
            end
        end
    end

    // Background stalls and clock-enable gaps, per mode.
    always @(posedge core_clk) begin
        #1;
        bseed = lfsr(bseed);
        stall = (mode == 2) || (mode == 1 && bseed[0]);
        clk_en = !(mode == 1 && bseed[3:2] == 2'b00);
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        $display("unexpected watchdog expected done seen running");
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        port_quad = 1'b1;
        pci_valid = 1'b0;
        pci_word = '0;
        stall = 1'b0;
        mode = 0;
        held = 1'b0;
        seed = 32'hE440;
        bseed = 32'hE440;
        error_cnt = 0;
        comparisons = 0;
        repeat (8) @(posedge core_clk);
        #1;
        chk("user_valid", 36'h0, user_valid);
        chk("user_word", 36'hF_0000_0000, user_word);
        chk("pci_ready", 36'h0, pci_ready);
        rst_b = 1'b1;
        @(posedge core_clk);
        #1;
        burst(1'b1, 6, 1'b0);
        burst(1'b0, 6, 1'b0);
        burst(1'b0, 5, 1'b1);
        burst(1'b0, 1, 1'b0);
        wait_empty();
        port_quad = 1'b0;
        // Let the mode pin pass its synchroniser before offering a word.
        repeat (3) @(posedge core_clk);
        #1;
        pci_word = {1'b0, 1'b1, 8'h00, 64'h0000_0000_A5C3_5A3C};
        pci_valid = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        chk("user_valid", 36'h0, user_valid);
        chk("pci_ready", 36'h0, pci_ready);
        port_quad = 1'b1;
        send(1'b0, 1'b1, 8'h00, 64'h0000_0000_A5C3_5A3C);
        pci_valid = 1'b0;
        wait_empty();
        mode = 2;
        burst(1'b1, 15, 1'b1);
        chk("queued", 36'd30, exp_q.size());
        chk("user_valid", 36'h1, user_valid);
        mode = 0;
        wait_empty();
        mode = 1;
        repeat (20) burst(seed[4], seed[2:0] + 1, 1'b1);
        mode = 0;
        wait_empty();
        end_of_test();
    end
endmodule
